//--- hdl/usbsp_bridge.v
// Top of the USB to serial port bridge: register slave, serial port, straps, modem lines.
// Assumes the USB function engine acts as an Avalon-MM master on the register port.
`include "usbsp_defs.vh"
`timescale 1ns/100ps
module usbsp_bridge #(
  parameter INVERTED_VARIANT = 0
) (
  // Clock and reset.
  input wire clk,
  input wire rst_b,
  // Register port.
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Serial data.
  output reg txd,
  input wire rxd,
  output reg rxd_pull_up,
  // Modem lines.
  output reg rts_out,
  output reg dtr_out,
  input wire cts_in,
  input wire dsr_in,
  input wire ri_in,
  input wire dcd_in,
  // Straps and auxiliary pins.
  input wire suspend_inhibit_n,
  input wire aux_line_mode_strap,
  input wire infrared_select_n,
  output reg config_done_n,
  output reg aux_clock_out,
  output reg usb_suspend
);

  localparam integer DIV_RESET_FULL = `USBSP_DIV_RESET;
  localparam [15:0] DIV_RESET = DIV_RESET_FULL[15:0];
  localparam INV = (INVERTED_VARIANT != 0);

  // ****************************************************************
  // Parity of a character in the selected mode.
  // ****************************************************************
  function par_bit;
    input [8:0] d;
    input nine;
    input [1:0] mode;
    reg x;
    begin
      x = ^d[7:0] ^ (nine & d[8]);
      case (mode)
        `USBSP_PAR_ODD: par_bit = ~x;
        `USBSP_PAR_EVEN: par_bit = x;
        `USBSP_PAR_MARK: par_bit = 1'b1;
        default: par_bit = 1'b0;
      endcase
    end
  endfunction

  // ****************************************************************
  // Registers and state.
  // ****************************************************************
  reg [7:0] ctrl;
  reg [15:0] div;
  reg [15:0] div_cnt;
  reg tick;
  reg straps_taken;
  reg sir_mode;
  reg aux_mode;
  reg [8:0] tx_hold;
  reg tx_full;
  reg tx_start;
  reg [8:0] rx_hold;
  reg rx_valid;
  reg overrun;
  reg frame_err;
  reg parity_err;
  reg [3:0] modem;
  reg [2:0] sir_cnt;
  reg rx_line;
  wire tx_busy;
  wire tx_ser;
  wire tx_pulse;
  wire rx_done;
  wire [9:0] rx_bits;
  wire rx_ferr;
  wire nine = ctrl[`USBSP_CT_NINE];
  wire par_en = ctrl[`USBSP_CT_PAR_EN];
  wire [1:0] par_mode = ctrl[`USBSP_CT_PAR_HI:`USBSP_CT_PAR_LO];
  wire [3:0] nbits = 4'h8 + {3'h0, nine} + {3'h0, par_en};
  wire [3:0] dbits = 4'h8 + {3'h0, nine};
  wire acc = avs_waitrequest ? 1'b0 : (avs_read | avs_write);
  wire wr = acc & avs_write;
  wire rd = acc & avs_read;
  wire wr_data = wr && avs_address == `USBSP_REG_DATA;
  wire rd_data = rd && avs_address == `USBSP_REG_DATA;
  wire wr_stat = wr && avs_address == `USBSP_REG_STATUS;
  wire rx_par = par_bit(rx_bits[8:0], nine, par_mode);
  reg [9:0] tx_frame;
  reg [31:0] next_readdata;
  reg [8:0] rx_char;
  integer i;

  // ****************************************************************
  // Bus slave with one wait state; a data write waits while the holding byte is full.
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if (avs_waitrequest) begin
      if ((avs_read | avs_write) &&
          !(avs_write && avs_address == `USBSP_REG_DATA && tx_full)) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= next_readdata;
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always @* begin
    next_readdata = 32'h00000000;
    case (avs_address)
      `USBSP_REG_DATA: next_readdata[8:0] = rx_hold;
      `USBSP_REG_STATUS: begin
        next_readdata[`USBSP_ST_RX_VALID] = rx_valid;
        next_readdata[`USBSP_ST_TX_FULL] = tx_full;
        next_readdata[`USBSP_ST_TX_BUSY] = tx_busy;
        next_readdata[`USBSP_ST_OVERRUN] = overrun;
        next_readdata[`USBSP_ST_FRAME_ERR] = frame_err;
        next_readdata[`USBSP_ST_PARITY_ERR] = parity_err;
        next_readdata[`USBSP_ST_DCD:`USBSP_ST_CTS] = modem;
        next_readdata[`USBSP_ST_SIR] = sir_mode;
        next_readdata[`USBSP_ST_AUX] = aux_mode;
        next_readdata[`USBSP_ST_SUSPEND] = usb_suspend;
      end
      `USBSP_REG_CTRL: next_readdata[7:0] = ctrl;
      `USBSP_REG_DIV: next_readdata[15:0] = div;
      default: next_readdata = 32'h00000000;
    endcase
  end

  // ****************************************************************
  // Control and divisor registers; straps caught once after reset.
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_b) begin
      ctrl <= `USBSP_CTRL_RESET;
      div <= DIV_RESET;
      straps_taken <= 1'b0;
      sir_mode <= 1'b0;
      aux_mode <= 1'b0;
    end else begin
      if (wr && avs_address == `USBSP_REG_CTRL) begin
        ctrl <= avs_writedata[7:0];
      end
      if (wr && avs_address == `USBSP_REG_DIV) begin
        div <= avs_writedata[15:0];
      end
      if (!straps_taken) begin
        straps_taken <= 1'b1;
        sir_mode <= INV ? ~infrared_select_n : 1'b0;
        aux_mode <= aux_line_mode_strap;
      end
    end
  end

  // ****************************************************************
  // Oversampling tick at six times the bit rate.
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_b) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (div_cnt >= div) begin
      div_cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // ****************************************************************
  // Transmit path: holding byte, frame assembly, line drive.
  // ****************************************************************
  always @* begin
    tx_frame = 10'h3ff;
    for (i = 0; i < 9; i = i + 1) begin
      if (i < dbits) begin
        tx_frame[i] = tx_hold[i];
      end
    end
    if (par_en) begin
      tx_frame[dbits] = par_bit(tx_hold, nine, par_mode);
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      tx_hold <= 9'h000;
      tx_full <= 1'b0;
      tx_start <= 1'b0;
    end else begin
      tx_start <= 1'b0;
      if (tx_full && !tx_busy && !tx_start) begin
        tx_full <= 1'b0;
        tx_start <= 1'b1;
      end else if (wr_data) begin
        tx_hold <= avs_writedata[8:0];
        tx_full <= 1'b1;
      end
    end
  end

  usbsp_tx usbsp_tx_inst (
    .clk(clk),
    .rst_b(rst_b),
    .tick(tick),
    .start(tx_start),
    .frame(tx_frame),
    .nbits(nbits),
    .busy(tx_busy),
    .ser(tx_ser),
    .pulse_win(tx_pulse)
  );

  always @(posedge clk) begin
    if (!rst_b) begin
      txd <= INV ? 1'b0 : 1'b1;
    end else if (sir_mode) begin
      txd <= ~tx_ser & tx_pulse;
    end else begin
      txd <= INV ? ~tx_ser : tx_ser;
    end
  end

  // ****************************************************************
  // Receive path: line conditioning, holding byte, error flags.
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_b) begin
      sir_cnt <= 3'h0;
      rx_line <= 1'b1;
    end else if (sir_mode) begin
      if (rxd) begin
        sir_cnt <= `USBSP_OVS;
      end else if (tick && sir_cnt != 3'h0) begin
        sir_cnt <= sir_cnt - 3'h1;
      end
      rx_line <= (sir_cnt == 3'h0) & ~rxd;
    end else begin
      rx_line <= rxd ^ aux_mode;
    end
  end

  always @* begin
    rx_char = rx_bits[8:0];
    if (!nine) begin
      rx_char[8] = 1'b0;
    end
  end

  usbsp_rx usbsp_rx_inst (
    .clk(clk),
    .rst_b(rst_b),
    .tick(tick),
    .line(rx_line),
    .nbits(nbits),
    .done(rx_done),
    .bits(rx_bits),
    .frame_err(rx_ferr)
  );

  always @(posedge clk) begin
    if (!rst_b) begin
      rx_hold <= 9'h000;
      rx_valid <= 1'b0;
      overrun <= 1'b0;
      frame_err <= 1'b0;
      parity_err <= 1'b0;
    end else begin
      if (rx_done) begin
        rx_hold <= rx_char;
        rx_valid <= 1'b1;
      end else if (rd_data) begin
        rx_valid <= 1'b0;
      end
      if (rx_done && rx_valid && !rd_data) begin
        overrun <= 1'b1;
      end else if (wr_stat && avs_writedata[`USBSP_ST_OVERRUN]) begin
        overrun <= 1'b0;
      end
      if (rx_done && rx_ferr) begin
        frame_err <= 1'b1;
      end else if (wr_stat && avs_writedata[`USBSP_ST_FRAME_ERR]) begin
        frame_err <= 1'b0;
      end
      if (rx_done && par_en && rx_bits[dbits] != rx_par) begin
        parity_err <= 1'b1;
      end else if (wr_stat && avs_writedata[`USBSP_ST_PARITY_ERR]) begin
        parity_err <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Modem lines, pull direction, suspend, clock and configured outputs.
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_b) begin
      modem <= 4'h0;
      rts_out <= INV ? 1'b0 : 1'b1;
      dtr_out <= INV ? 1'b0 : 1'b1;
      rxd_pull_up <= 1'b1;
      usb_suspend <= 1'b0;
      aux_clock_out <= 1'b0;
      config_done_n <= 1'b1;
    end else begin
      modem <= INV ? {dcd_in, ri_in, dsr_in, cts_in} : ~{dcd_in, ri_in, dsr_in, cts_in};
      rts_out <= INV ? ctrl[`USBSP_CT_RTS] : ~ctrl[`USBSP_CT_RTS];
      dtr_out <= INV ? ctrl[`USBSP_CT_DTR] : ~ctrl[`USBSP_CT_DTR];
      rxd_pull_up <= ~(aux_mode | sir_mode);
      usb_suspend <= ctrl[`USBSP_CT_SUSPEND_REQ] & suspend_inhibit_n;
      aux_clock_out <= INV ? 1'b0 : ~aux_clock_out;
      if (INV) begin
        config_done_n <= ~ctrl[`USBSP_CT_CONFIGURED];
      end else begin
        config_done_n <= aux_clock_out;
      end
    end
  end

endmodule // usbsp_bridge

//--- shared/usbsp_defs.vh
// Constants of the USB to serial port bridge: register map, fields, resets, timing.
// Assumes a 12 MHz clock and an Avalon-MM slave port with byte addresses.
`ifndef USBSP_DEFS_VH
`define USBSP_DEFS_VH

// ****************************************************************
// Register offsets (byte addresses).
// ****************************************************************
`define USBSP_REG_DATA 4'h0
`define USBSP_REG_STATUS 4'h4
`define USBSP_REG_CTRL 4'h8
`define USBSP_REG_DIV 4'hc

// ****************************************************************
// Status fields.
// ****************************************************************
`define USBSP_ST_RX_VALID 0
`define USBSP_ST_TX_FULL 1
`define USBSP_ST_TX_BUSY 2
`define USBSP_ST_OVERRUN 3
`define USBSP_ST_FRAME_ERR 4
`define USBSP_ST_PARITY_ERR 5
`define USBSP_ST_CTS 6
`define USBSP_ST_DSR 7
`define USBSP_ST_RI 8
`define USBSP_ST_DCD 9
`define USBSP_ST_SIR 10
`define USBSP_ST_AUX 11
`define USBSP_ST_SUSPEND 12

// ****************************************************************
// Control fields and reset value.
// ****************************************************************
`define USBSP_CT_RTS 0
`define USBSP_CT_DTR 1
`define USBSP_CT_NINE 2
`define USBSP_CT_PAR_EN 3
`define USBSP_CT_PAR_LO 4
`define USBSP_CT_PAR_HI 5
`define USBSP_CT_CONFIGURED 6
`define USBSP_CT_SUSPEND_REQ 7
`define USBSP_CTRL_RESET 8'h00

// ****************************************************************
// Parity modes.
// ****************************************************************
`define USBSP_PAR_ODD 2'h0
`define USBSP_PAR_EVEN 2'h1
`define USBSP_PAR_MARK 2'h2
`define USBSP_PAR_SPACE 2'h3

// ****************************************************************
// Timing.
// ****************************************************************
`define USBSP_CLK_HZ 12000000
`define USBSP_BAUD_RESET 9600
`define USBSP_OVS 3'h6
`define USBSP_MID 3'h2
`define USBSP_DIV_RESET (`USBSP_CLK_HZ / (6 * `USBSP_BAUD_RESET) - 1)

`endif

//--- hdl/usbsp_tx.v
// Serial transmitter: shifts start, data, optional parity and stop bits.
// Assumes a tick at six times the bit rate and a frame padded with ones.
`timescale 1ns/100ps
module usbsp_tx (
  // Clock and reset.
  input wire clk,
  input wire rst_b,
  // Control.
  input wire tick,
  input wire start,
  input wire [9:0] frame,
  input wire [3:0] nbits,
  // Status and line.
  output reg busy,
  output reg ser,
  output reg pulse_win
);

  reg [11:0] sh;
  reg [3:0] left;
  reg [2:0] sub;

  always @(posedge clk) begin
    if (!rst_b) begin
      busy <= 1'b0;
      ser <= 1'b1;
      pulse_win <= 1'b0;
      sh <= 12'hfff;
      left <= 4'h0;
      sub <= 3'h0;
    end else if (!busy) begin
      ser <= 1'b1;
      pulse_win <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        sh <= {1'b1, frame, 1'b0};
        left <= nbits + 4'h2;
        sub <= 3'h0;
      end
    end else if (tick) begin
      ser <= sh[0];
      pulse_win <= (sub == 3'h0);
      if (sub == `USBSP_OVS - 3'h1) begin
        sub <= 3'h0;
        sh <= {1'b1, sh[11:1]};
        left <= left - 4'h1;
        if (left == 4'h1) begin
          busy <= 1'b0;
        end
      end else begin
        sub <= sub + 3'h1;
      end
    end
  end

endmodule // usbsp_tx

//--- hdl/usbsp_rx.v
// Serial receiver: finds the start bit, samples each bit at its middle.
// Assumes a tick at six times the bit rate and a line idling high.
`timescale 1ns/100ps
module usbsp_rx (
  // Clock and reset.
  input wire clk,
  input wire rst_b,
  // Control.
  input wire tick,
  input wire line,
  input wire [3:0] nbits,
  // Result.
  output reg done,
  output reg [9:0] bits,
  output reg frame_err
);

  reg active;
  reg [3:0] idx;
  reg [2:0] sub;

  always @(posedge clk) begin
    if (!rst_b) begin
      active <= 1'b0;
      idx <= 4'h0;
      sub <= 3'h0;
      done <= 1'b0;
      bits <= 10'h000;
      frame_err <= 1'b0;
    end else begin
      done <= 1'b0;
      if (tick) begin
        if (!active) begin
          if (!line) begin
            active <= 1'b1;
            idx <= 4'h0;
            sub <= 3'h1;
          end
        end else if (sub == `USBSP_MID) begin
          sub <= sub + 3'h1;
          if (idx == 4'h0 && line) begin
            active <= 1'b0;
          end else if (idx == nbits + 4'h1) begin
            active <= 1'b0;
            done <= 1'b1;
            frame_err <= ~line;
          end else if (idx != 4'h0) begin
            bits[idx - 4'h1] <= line;
          end
        end else if (sub == `USBSP_OVS - 3'h1) begin
          sub <= 3'h0;
          idx <= idx + 4'h1;
        end else begin
          sub <= sub + 3'h1;
        end
      end
    end
  end

endmodule // usbsp_rx

//--- sim/usbsp_props.sv
// Checker for the bridge top: bus handshake, idle levels, clock pins, straps.
// Assumes it is bound to every bridge instance by the statement at the foot.
`include "usbsp_defs.vh"
`timescale 1ns/100ps
module usbsp_props #(
  parameter INVERTED_VARIANT = 0
) (
  // Clock, reset and bus.
  input wire clk,
  input wire rst_b,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  // Pins.
  input wire txd,
  input wire rxd_pull_up,
  input wire rts_out,
  input wire dtr_out,
  input wire suspend_inhibit_n,
  input wire aux_line_mode_strap,
  input wire config_done_n,
  input wire aux_clock_out,
  input wire usb_suspend
);
  // ****
  // Strap capture model and checks.
  // ****
  reg first;
  reg aux_cap;
  always @(posedge clk) begin
    if (!rst_b) begin
      first <= 1'b1;
      aux_cap <= 1'b0;
    end else if (first) begin
      first <= 1'b0;
      aux_cap <= aux_line_mode_strap;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  read_answer_a: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read not answered in one cycle");
  answer_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("answer without request");
  suspend_gate_a: assert property (usb_suspend |-> $past(suspend_inhibit_n))
    else $error("suspend while inhibited");
  clock_toggle_a: assert property (INVERTED_VARIANT == 0 && $past(rst_b)
    |-> aux_clock_out != $past(aux_clock_out))
    else $error("clock output not toggling");
  clock_pair_a: assert property (INVERTED_VARIANT == 0 |-> config_done_n == !aux_clock_out)
    else $error("clock outputs not complementary");
  tx_start_a: assert property (INVERTED_VARIANT == 0 && avs_write && !avs_waitrequest
    && avs_address == `USBSP_REG_DATA |-> ##[1:400] !txd)
    else $error("no start bit after data write");
  reset_idle_a: assert property ($rose(rst_b) |-> txd == (INVERTED_VARIANT == 0)
    && rts_out == (INVERTED_VARIANT == 0) && dtr_out == (INVERTED_VARIANT == 0)
    && rxd_pull_up && !usb_suspend)
    else $error("outputs not idle after reset");
  pull_follow_a: assert property (INVERTED_VARIANT == 0 && !first && !$past(first)
    |-> rxd_pull_up == !aux_cap)
    else $error("pull direction does not match strap");
  cover property (avs_read && !avs_waitrequest);
  cover property (avs_write && avs_waitrequest [*3]);
  cover property ($fell(txd));
endmodule // usbsp_props
bind usbsp_bridge usbsp_props #(.INVERTED_VARIANT(INVERTED_VARIANT)) usbsp_props_inst (.clk,
  .rst_b, .avs_address, .avs_read, .avs_write, .avs_waitrequest, .txd, .rxd_pull_up, .rts_out,
  .dtr_out, .suspend_inhibit_n, .aux_line_mode_strap, .config_done_n, .aux_clock_out,
  .usb_suspend);

//--- sim/usbsp_peer.sv
// Serial peer model: frames bytes onto rxd and collects frames seen on txd.
// Assumes an idle-high line and a bit time given in clock cycles.
`timescale 1ns/100ps
module usbsp_peer #(
  parameter int BIT = 12
) (
  // Clock and line.
  input wire clk,
  input wire txd,
  input wire extra_bit,
  output logic rxd
);
  // ****
  // Receiver and sender.
  // ****
  logic [9:0] got[$];
  logic [9:0] v;
  initial rxd = 1'b1;
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    v = '0;
    for (int i = 0; i < 8 + extra_bit; i++) begin
      repeat (BIT) @(posedge clk);
      v[i] = txd;
    end
    repeat (BIT) @(posedge clk);
    v[9] = txd;
    got.push_back(v);
  end
  task automatic send(input logic [7:0] b);
    rxd <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      repeat (BIT) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask
endmodule // usbsp_peer

//--- sim/usbsp_bridge_tb.sv
// Testbench of the bridge: register tasks, serial peer, modem and strap checks.
// Assumes the checker binds itself and a small divider keeps frames short.
`include "usbsp_defs.vh"
`timescale 1ns/100ps
module usbsp_bridge_tb;
  localparam int DIVV = 1;
  localparam int BIT = 6 * (DIVV + 1);
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [3:0] avs_address = 4'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [3:0] modem_n = 4'hf;
  reg suspend_inhibit_n = 1'b1;
  reg aux_line_mode_strap = 1'b0;
  reg extra_bit = 1'b0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, txd, rxd, rxd_pull_up, rts_out, dtr_out;
  wire config_done_n, aux_clock_out, usb_suspend;
  wire [31:0] avs_readdata_inv;
  wire txd_inv, rxd_pull_up_inv, rts_inv, dtr_inv;
  wire config_done_n_inv, aux_clock_out_inv, usb_suspend_inv;
  int sir_pulses = 0;
  int errors = 0;
  int n_checks = 0;
  logic [31:0] q;
  logic [31:0] q2;
  logic [15:0] tx_t [5] = '{16'h8031, 16'h8131, 16'h8231, 16'h8331, 16'h0511};
  usbsp_bridge #(.INVERTED_VARIANT(0)) usbsp_bridge_inst (.clk, .rst_b, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .txd, .rxd,
    .rxd_pull_up, .rts_out, .dtr_out, .cts_in(modem_n[0]), .dsr_in(modem_n[1]),
    .ri_in(modem_n[2]), .dcd_in(modem_n[3]), .suspend_inhibit_n, .aux_line_mode_strap,
    .infrared_select_n(1'b1), .config_done_n, .aux_clock_out, .usb_suspend);
  usbsp_peer #(.BIT(BIT)) usbsp_peer_inst (.clk, .txd, .extra_bit, .rxd);
  // Inverted variant on the same bus, strapped for infrared and auxiliary mode.
  usbsp_bridge #(.INVERTED_VARIANT(1)) usbsp_bridge_inv_inst (.clk, .rst_b, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata(avs_readdata_inv),
    .avs_waitrequest(), .txd(txd_inv), .rxd(1'b0), .rxd_pull_up(rxd_pull_up_inv),
    .rts_out(rts_inv), .dtr_out(dtr_inv), .cts_in(modem_n[0]), .dsr_in(modem_n[1]),
    .ri_in(modem_n[2]), .dcd_in(modem_n[3]), .suspend_inhibit_n,
    .aux_line_mode_strap(1'b1), .infrared_select_n(1'b0), .config_done_n(config_done_n_inv),
    .aux_clock_out(aux_clock_out_inv), .usb_suspend(usb_suspend_inv));
  // Counts the infrared pulses, one for each zero bit sent.
  always @(posedge txd_inv) begin
    sir_pulses++;
  end
  // ****
  // Tasks.
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic bus(input bit we, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= !we;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 2000);
    if (avs_waitrequest !== 1'b0) begin
      errors++;
      conclude();
    end
    q = avs_readdata;
    q2 = avs_readdata_inv;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(0, a, 0);
    chk(q & m, exp);
  endtask
  task automatic wait_rx;
    int n;
    n = 0;
    do begin
      bus(0, `USBSP_REG_STATUS, 0);
      n++;
    end while (q[`USBSP_ST_RX_VALID] !== 1'b1 && n < 200);
    if (q[`USBSP_ST_RX_VALID] !== 1'b1) begin
      errors++;
      conclude();
    end
  endtask
  task automatic take(input logic [9:0] exp);
    int n;
    n = 0;
    while (usbsp_peer_inst.got.size() == 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      errors++;
      conclude();
    end
    chk(usbsp_peer_inst.got.pop_front(), exp);
    repeat (BIT) @(posedge clk);
  endtask
  // ****
  // Sequence.
  // ****
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    aux_line_mode_strap <= 1'b1;
    rdc(`USBSP_REG_CTRL, 32'hff, `USBSP_CTRL_RESET);
    rdc(`USBSP_REG_DIV, 32'hffff, `USBSP_DIV_RESET);
    bus(1, 4'h2, 32'hffffffff);
    rdc(4'h2, 32'hffffffff, 0);
    rdc(`USBSP_REG_STATUS, 32'h800, 0);
    chk(q2 & 32'hc00, 32'hc00);
    chk(rxd_pull_up, 1);
    chk(rxd_pull_up_inv, 0);
    chk(aux_clock_out_inv, 0);
    chk(config_done_n_inv, 1);
    chk(txd_inv, 0);
    $display("test reset and straps done");
    for (int i = 0; i < 16; i++) begin
      modem_n <= ~i[3:0];
      rdc(`USBSP_REG_STATUS, 32'h3c0, i << 6);
      chk(q2 & 32'h3c0, (~i & 15) << 6);
    end
    for (int i = 0; i < 4; i++) begin
      bus(1, `USBSP_REG_CTRL, i);
      repeat (2) @(posedge clk);
      #1 chk({dtr_out, rts_out}, ~i & 3);
      chk({dtr_inv, rts_inv}, i & 3);
    end
    bus(1, `USBSP_REG_CTRL, 32'h80);
    repeat (2) @(posedge clk);
    #1 chk(usb_suspend, 1);
    chk(usb_suspend_inv, 1);
    suspend_inhibit_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(usb_suspend, 0);
    suspend_inhibit_n <= 1'b1;
    bus(1, `USBSP_REG_CTRL, 32'h40);
    repeat (2) @(posedge clk);
    #1 chk(config_done_n_inv, 0);
    $display("test modem and suspend done");
    bus(1, `USBSP_REG_DIV, DIVV);
    bus(1, `USBSP_REG_CTRL, 0);
    bus(1, `USBSP_REG_DATA, 8'h55);
    bus(1, `USBSP_REG_DATA, 8'ha3);
    bus(1, `USBSP_REG_DATA, 8'h0f);
    take(10'h255);
    take(10'h2a3);
    take(10'h20f);
    extra_bit <= 1'b1;
    foreach (tx_t[k]) begin
      bus(1, `USBSP_REG_CTRL, tx_t[k][15:12] == 0 ? 4 : 8 | tx_t[k][9:8] << 4);
      bus(1, `USBSP_REG_DATA, tx_t[k][15:12] == 0 ? 9'h1a5 : 8'h31);
      take(tx_t[k][15:12] == 0 ? 10'h3a5 : 10'h231 | (tx_t[k][9:8] % 3 != 0) << 8);
    end
    extra_bit <= 1'b0;
    bus(1, `USBSP_REG_CTRL, 0);
    chk(sir_pulses, 46);
    $display("test transmit done");
    fork
      usbsp_peer_inst.send(8'h3c);
      bus(1, `USBSP_REG_DATA, 8'hc3);
    join
    take(10'h2c3);
    wait_rx();
    rdc(`USBSP_REG_DATA, 32'hff, 8'h3c);
    foreach (tx_t[k]) begin
      usbsp_peer_inst.send(8'h81 ^ k);
      wait_rx();
      rdc(`USBSP_REG_DATA, 32'hff, 8'h81 ^ k);
    end
    usbsp_peer_inst.send(8'haa);
    usbsp_peer_inst.send(8'h55);
    rdc(`USBSP_REG_STATUS, 32'h9, 32'h9);
    rdc(`USBSP_REG_DATA, 32'hff, 8'h55);
    bus(1, `USBSP_REG_STATUS, 32'h8);
    rdc(`USBSP_REG_STATUS, 32'h9, 0);
    $display("test receive done");
    conclude();
  end
endmodule // usbsp_bridge_tb
